//--- rtl/nfct_pkg.sv
// Constants, register map and encodings for the protocol timer block.
// Assumes a single 40 MHz clock domain and a plain register port.
package nfct_pkg;

  // Register byte offsets.
  localparam logic [7:0] NFCT_CTRL_OFS   = 8'h00;
  localparam logic [7:0] NFCT_MRT_OFS    = 8'h04;
  localparam logic [7:0] NFCT_NRT_OFS    = 8'h08;
  localparam logic [7:0] NFCT_PFW_OFS    = 8'h0c;
  localparam logic [7:0] NFCT_GPT_OFS    = 8'h10;
  localparam logic [7:0] NFCT_STAT_OFS   = 8'h14;
  localparam logic [7:0] NFCT_CMD_OFS    = 8'h18;

  // Control register field positions.
  localparam int NFCT_MODE_LSB    = 0;
  localparam int NFCT_MRT_STEP    = 4;
  localparam int NFCT_NRT_STEP    = 5;
  localparam int NFCT_NRT_UNCOND  = 6;
  localparam int NFCT_NRT_FIELD   = 7;
  localparam int NFCT_GPT_TRIG    = 8;
  localparam int NFCT_SQ_EN       = 9;
  localparam int NFCT_SQ_CMD      = 10;
  localparam int NFCT_CTRL_W      = 11;

  // Status register field positions: flags then running bits.
  localparam int NFCT_STAT_FLAG   = 0;
  localparam int NFCT_STAT_RUN    = 4;

  // Reset values.
  localparam logic [NFCT_CTRL_W-1:0] NFCT_CTRL_RST = 11'h000;
  localparam logic [15:0]            NFCT_CNT_RST  = 16'h0000;

  // Timer indices.
  localparam int NFCT_MRT = 0;
  localparam int NFCT_NRT = 1;
  localparam int NFCT_PFW = 2;
  localparam int NFCT_GPT = 3;

  // Step lengths minus one: carrier periods, or RC oscillator ticks for the RC step.
  localparam logic [12:0] NFCT_STEP64_LAST   = 13'h003f;
  localparam logic [12:0] NFCT_STEP512_LAST  = 13'h01ff;
  localparam logic [12:0] NFCT_STEP4096_LAST = 13'h0fff;
  localparam logic [12:0] NFCT_STEPRC_LAST   = 13'h0000;

  typedef enum logic [2:0] {
    NFCT_READER  = 3'h0,
    NFCT_ACT_INI = 3'h1,
    NFCT_ACT_TGT = 3'h2,
    NFCT_PAS_TGT = 3'h3,
    NFCT_BITRATE = 3'h4,
    NFCT_LP_TGT  = 3'h5
  } nfct_mode_e;

  // Direct command codes written to the command register.
  localparam logic [7:0] NFCT_CMD_STOP_ALL  = 8'h01;
  localparam logic [7:0] NFCT_CMD_START_MRT = 8'h02;
  localparam logic [7:0] NFCT_CMD_START_NRT = 8'h03;
  localparam logic [7:0] NFCT_CMD_STOP_NRT  = 8'h04;
  localparam logic [7:0] NFCT_CMD_START_GPT = 8'h05;

endpackage

//--- rtl/nfct_timers.sv
// Receive-mask, no-response, peer-field waiting and general purpose timers.
// Assumes framing events are one-cycle pulses on clock_i and a carrier tick input.
//
// What this block does
// - Stop-all command halts every timer, except unconditional no-response timer.
// - Receive-mask timer holds receiver enable low while running; it raises no flag.
// - Squelch is switched on while receive-mask timer counts, when squelch enabled.
// - Receive-mask timer starts at end of transmitted frame.
// - Start-mask command launches the timer; squelch follows the command squelch setting.
// - Peer field-on starts receive-mask timer in active and passive target modes.
// - Mask step bit selects 64 or 512 carrier periods per step.
// - Low-power target uses RC oscillator ticks until crystal is stable.
// - No-response timer starts at end of transmission in reader mode and flags its expiry.
// - No-response step bit selects 64 or 4096 carrier periods per step.
// - Normal mode: expiry flags and disables receiver; reply start stops silently.
// - Unconditional mode: always flags, ignores stop-all, disables receiver if idle.
// - Start-no-response command starts or restarts the no-response timer.
// - Stop-no-response, or stop-all in normal mode, ends it without flag.
// - Active modes: field select chooses own field off or peer field-on start.
// - Passive target mode never starts the no-response timer automatically.
// - Peer-field wait timer starts at own field off, flags unless field-on arrives.
// - General timer starts at reception start or end, or at end of transmission in active modes; flags on every expiry.
// - In active modes the general timer times switching off of own field.
// - Start-general command starts or restarts the general timer.
`timescale 1ns/10ps
`default_nettype none
module nfct_timers
  import nfct_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        fc_tick_i,
  input  wire logic        rc_osc_i,
  input  wire logic        osc_ok_i,
  input  wire logic        tx_end_i,
  input  wire logic        rx_start_i,
  input  wire logic        rx_end_i,
  input  wire logic        rx_busy_i,
  input  wire logic        field_on_i,
  output logic             rx_on_o,
  output logic             squelch_o,
  output logic             field_off_o,
  output logic             nre_flag_o,
  output logic             peer_field_wait_flag_o,
  output logic             gpt_flag_o
);

  logic [NFCT_CTRL_W-1:0] ctrl_q;
  logic [7:0]             mrt_cnt_q;
  logic [15:0]            nrt_cnt_q;
  logic [7:0]             pfw_cnt_q;
  logic [15:0]            gpt_cnt_q;
  logic [2:0]             flag_q;
  logic [3:0]             run_q;
  logic [15:0]            cnt_q [4];
  logic [12:0]            pre_q [4];
  logic                   mrt_cmd_q;
  logic                   rx_off_q;
  logic [2:0]             rc_sync_q;
  logic [2:0]             ok_sync_q;
  logic                   rc_lvl_q;
  logic                   ok_lvl_q;

  wire nfct_mode_e mode_w    = nfct_mode_e'(ctrl_q[NFCT_MODE_LSB +: 3]);
  wire             uncond_w  = ctrl_q[NFCT_NRT_UNCOND];
  wire             act_w     = (mode_w == NFCT_ACT_INI) || (mode_w == NFCT_ACT_TGT);
  wire             act_br_w  = act_w || (mode_w == NFCT_BITRATE);
  wire             p2p_w     = (mode_w != NFCT_READER);

  // Register decode.
  wire wr_ctrl_w = wr_i && (addr_i == NFCT_CTRL_OFS);
  wire wr_mrt_w  = wr_i && (addr_i == NFCT_MRT_OFS);
  wire wr_nrt_w  = wr_i && (addr_i == NFCT_NRT_OFS);
  wire wr_pfw_w  = wr_i && (addr_i == NFCT_PFW_OFS);
  wire wr_gpt_w  = wr_i && (addr_i == NFCT_GPT_OFS);
  wire wr_stat_w = wr_i && (addr_i == NFCT_STAT_OFS);
  wire wr_cmd_w  = wr_i && (addr_i == NFCT_CMD_OFS);

  wire cmd_stop_all_w = wr_cmd_w && (wdata_i[7:0] == NFCT_CMD_STOP_ALL);
  wire cmd_mrt_w      = wr_cmd_w && (wdata_i[7:0] == NFCT_CMD_START_MRT);
  wire cmd_nrt_w      = wr_cmd_w && (wdata_i[7:0] == NFCT_CMD_START_NRT);
  wire cmd_stop_nrt_w = wr_cmd_w && (wdata_i[7:0] == NFCT_CMD_STOP_NRT);
  wire cmd_gpt_w      = wr_cmd_w && (wdata_i[7:0] == NFCT_CMD_START_GPT);

  wire [31:0] rd_mux_w =
    (addr_i == NFCT_CTRL_OFS) ? {21'h000000, ctrl_q} :
    (addr_i == NFCT_MRT_OFS)  ? {24'h000000, mrt_cnt_q} :
    (addr_i == NFCT_NRT_OFS)  ? {16'h0000, nrt_cnt_q} :
    (addr_i == NFCT_PFW_OFS)  ? {24'h000000, pfw_cnt_q} :
    (addr_i == NFCT_GPT_OFS)  ? {16'h0000, gpt_cnt_q} :
    (addr_i == NFCT_STAT_OFS) ? {24'h000000, run_q, 1'b0, flag_q} :
    32'h00000000;

  // Pin inputs pass three flops; a level counts once the last two agree.
  wire rc_lvl_d = (rc_sync_q[1] == rc_sync_q[2]) ? rc_sync_q[2] : rc_lvl_q;
  wire ok_lvl_d = (ok_sync_q[1] == ok_sync_q[2]) ? ok_sync_q[2] : ok_lvl_q;
  wire rc_tick_w = rc_lvl_d && !rc_lvl_q;

  wire mrt_rc_w = (mode_w == NFCT_LP_TGT) && !ok_lvl_q;

  logic [3:0]  start_w;
  logic [3:0]  stop_w;
  logic [3:0]  tick_w;
  logic [3:0]  expire_w;
  logic [12:0] last_w [4];
  logic [15:0] load_w [4];

  // Own field switched off by general timer.
  wire own_off_w = expire_w[NFCT_GPT] && act_br_w;

  assign start_w[NFCT_MRT] = tx_end_i || cmd_mrt_w ||
                             (field_on_i && (act_w || mode_w == NFCT_PAS_TGT ||
                                             mode_w == NFCT_LP_TGT));
  assign start_w[NFCT_NRT] = cmd_nrt_w ||
                             (tx_end_i && mode_w == NFCT_READER) ||
                             (own_off_w && !ctrl_q[NFCT_NRT_FIELD]) ||
                             (field_on_i && act_w && ctrl_q[NFCT_NRT_FIELD]);
  // Peer-field wait starts at own field off.
  assign start_w[NFCT_PFW] = own_off_w && p2p_w;
  assign start_w[NFCT_GPT] = cmd_gpt_w ||
                             (act_br_w ? tx_end_i :
                              (ctrl_q[NFCT_GPT_TRIG] ? rx_end_i : rx_start_i));

  assign stop_w[NFCT_MRT] = cmd_stop_all_w;
  assign stop_w[NFCT_NRT] = cmd_stop_nrt_w ||
                            (!uncond_w && (cmd_stop_all_w || rx_start_i));
  assign stop_w[NFCT_PFW] = cmd_stop_all_w || field_on_i;
  assign stop_w[NFCT_GPT] = cmd_stop_all_w;

  assign last_w[NFCT_MRT] = mrt_rc_w ? NFCT_STEPRC_LAST :
                            (ctrl_q[NFCT_MRT_STEP] ? NFCT_STEP512_LAST : NFCT_STEP64_LAST);
  assign last_w[NFCT_NRT] = ctrl_q[NFCT_NRT_STEP] ? NFCT_STEP4096_LAST : NFCT_STEP64_LAST;
  assign last_w[NFCT_PFW] = NFCT_STEP64_LAST;
  assign last_w[NFCT_GPT] = NFCT_STEP64_LAST;

  assign tick_w = {fc_tick_i, fc_tick_i, fc_tick_i, mrt_rc_w ? rc_tick_w : fc_tick_i};

  assign load_w[NFCT_MRT] = {8'h00, mrt_cnt_q};
  assign load_w[NFCT_NRT] = nrt_cnt_q;
  assign load_w[NFCT_PFW] = {8'h00, pfw_cnt_q};
  assign load_w[NFCT_GPT] = gpt_cnt_q;

  // Counting core, one per timer.
  // A count of zero behaves as one, so a timer never hangs waiting at zero.
  // Start beats stop, so a restart command always wins over a stop event.
  for (genvar i = 0; i < 4; i++) begin : g_tmr
    wire step_w = run_q[i] && tick_w[i] && (pre_q[i] == last_w[i]);
    assign expire_w[i] = step_w && (cnt_q[i] <= 16'h0001);
    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        run_q[i] <= 1'b0;
        cnt_q[i] <= NFCT_CNT_RST;
        pre_q[i] <= 13'h0000;
      end else if (start_w[i]) begin
        run_q[i] <= 1'b1;
        cnt_q[i] <= load_w[i];
        pre_q[i] <= 13'h0000;
      end else if (stop_w[i] || expire_w[i]) begin
        run_q[i] <= 1'b0;
      end else if (run_q[i] && tick_w[i]) begin
        pre_q[i] <= step_w ? 13'h0000 : pre_q[i] + 13'h0001;
        cnt_q[i] <= step_w ? cnt_q[i] - 16'h0001 : cnt_q[i];
      end
    end
  end

  wire rx_off_set_w = expire_w[NFCT_NRT] && (!uncond_w || !rx_busy_i);
  wire rx_off_d     = rx_off_set_w || (rx_off_q && !tx_end_i && !start_w[NFCT_NRT]);
  // Command launch remembers which squelch setting applies.
  wire mrt_cmd_d    = cmd_mrt_w ? 1'b1 : (start_w[NFCT_MRT] ? 1'b0 : mrt_cmd_q);
  // Receiver enable low while the mask timer runs.
  wire rx_on_d      = !run_q[NFCT_MRT] && !rx_off_q;
  wire squelch_d    = run_q[NFCT_MRT] &&
                      (mrt_cmd_q ? ctrl_q[NFCT_SQ_CMD] : ctrl_q[NFCT_SQ_EN]);
  // Flags set by expiry win over a write-one clear.
  wire [2:0] flag_ev_w = {expire_w[NFCT_GPT], expire_w[NFCT_PFW], expire_w[NFCT_NRT]};
  wire [2:0] flag_d    = flag_ev_w | (flag_q & ~(wr_stat_w ? wdata_i[2:0] : 3'h0));

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rc_sync_q <= 3'h0;
      ok_sync_q <= 3'h0;
      rc_lvl_q  <= 1'b0;
      ok_lvl_q  <= 1'b0;
    end else begin
      rc_sync_q <= {rc_sync_q[1:0], rc_osc_i};
      ok_sync_q <= {ok_sync_q[1:0], osc_ok_i};
      rc_lvl_q  <= rc_lvl_d;
      ok_lvl_q  <= ok_lvl_d;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q    <= NFCT_CTRL_RST;
      mrt_cnt_q <= 8'h00;
      nrt_cnt_q <= NFCT_CNT_RST;
      pfw_cnt_q <= 8'h00;
      gpt_cnt_q <= NFCT_CNT_RST;
    end else begin
      if (wr_ctrl_w) ctrl_q <= wdata_i[NFCT_CTRL_W-1:0];
      if (wr_mrt_w) mrt_cnt_q <= wdata_i[7:0];
      if (wr_nrt_w) nrt_cnt_q <= wdata_i[15:0];
      if (wr_pfw_w) pfw_cnt_q <= wdata_i[7:0];
      if (wr_gpt_w) gpt_cnt_q <= wdata_i[15:0];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o                <= 32'h00000000;
      flag_q                 <= 3'h0;
      rx_off_q               <= 1'b0;
      mrt_cmd_q              <= 1'b0;
      rx_on_o                <= 1'b1;
      squelch_o              <= 1'b0;
      field_off_o            <= 1'b0;
      nre_flag_o             <= 1'b0;
      peer_field_wait_flag_o <= 1'b0;
      gpt_flag_o             <= 1'b0;
    end else begin
      rdata_o                <= rd_i ? rd_mux_w : 32'h00000000;
      flag_q                 <= flag_d;
      rx_off_q               <= rx_off_d;
      mrt_cmd_q              <= mrt_cmd_d;
      rx_on_o                <= rx_on_d;
      squelch_o              <= squelch_d;
      field_off_o            <= own_off_w;
      nre_flag_o             <= flag_ev_w[0];
      peer_field_wait_flag_o <= flag_ev_w[1];
      gpt_flag_o             <= flag_ev_w[2];
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  mrt_rxon_a: assert property (run_q[NFCT_MRT] |=> !rx_on_o)
    else $error("receiver enabled while mask timer runs");
  mrt_squelch_a: assert property (run_q[NFCT_MRT] && !mrt_cmd_q && ctrl_q[NFCT_SQ_EN]
    |=> squelch_o) else $error("squelch not on during mask timer");
  mrt_start_a: assert property (tx_end_i |=> run_q[NFCT_MRT] &&
    cnt_q[NFCT_MRT] == {8'h00, $past(mrt_cnt_q)}) else $error("mask timer did not start");
  stop_all_a: assert property (cmd_stop_all_w && start_w == 4'h0 && !uncond_w
    |=> run_q == 4'h0) else $error("timer running after stop all");
  nrt_exempt_a: assert property (cmd_stop_all_w && uncond_w && run_q[NFCT_NRT]
    && !expire_w[NFCT_NRT] |=> run_q[NFCT_NRT]) else $error("stop all halted exempt timer");
  nrt_reply_a: assert property (rx_start_i && !uncond_w && !start_w[NFCT_NRT]
    && !expire_w[NFCT_NRT] |=> !run_q[NFCT_NRT] ##1 !nre_flag_o)
    else $error("reply start did not stop no-response timer");
  sequence nrt_exp_s;
    expire_w[NFCT_NRT] && !uncond_w && !tx_end_i && !start_w[NFCT_NRT];
  endsequence
  nrt_rxoff_a: assert property (nrt_exp_s |=> nre_flag_o ##1 !rx_on_o)
    else $error("no-response expiry did not flag and disable receiver");
  nrt_start_a: assert property (tx_end_i && mode_w == NFCT_READER |=> run_q[NFCT_NRT])
    else $error("no-response timer did not start");
  nrt_passive_a: assert property (mode_w == NFCT_PAS_TGT && !run_q[NFCT_NRT]
    && !cmd_nrt_w |=> !run_q[NFCT_NRT]) else $error("no-response started in passive target");
  pfw_stop_a: assert property (field_on_i && !start_w[NFCT_PFW]
    |=> !run_q[NFCT_PFW] ##1 !peer_field_wait_flag_o) else $error("wait timer not stopped");
  gpt_cmd_a: assert property (cmd_gpt_w |=> run_q[NFCT_GPT] &&
    cnt_q[NFCT_GPT] == $past(gpt_cnt_q) && pre_q[NFCT_GPT] == 13'h0000)
    else $error("general timer not restarted");
  nrt_step_a: assert property (run_q[NFCT_NRT] |-> pre_q[NFCT_NRT] <= last_w[NFCT_NRT])
    else $error("no-response prescaler beyond step");

  // A stopped no-response timer stays quiet.
  sequence nrt_quiet_s;
    !run_q[NFCT_NRT] ##1 !nre_flag_o;
  endsequence
  // The general timer ends the own field in active modes.
  sequence gpt_own_off_s;
    expire_w[NFCT_GPT] && act_br_w;
  endsequence

  mrt_cmd_a: assert property (cmd_mrt_w |=> run_q[NFCT_MRT] && mrt_cmd_q)
    else $error("mask command did not launch timer");
  mrt_peer_a: assert property (field_on_i && act_w |=> run_q[NFCT_MRT])
    else $error("peer field-on did not start mask timer");
  mrt_step_a: assert property (run_q[NFCT_MRT] && !ctrl_q[NFCT_MRT_STEP] && !mrt_rc_w
    |-> pre_q[NFCT_MRT] <= NFCT_STEP64_LAST) else $error("mask prescaler beyond step");
  rc_hold_a: assert property (mrt_rc_w && run_q[NFCT_MRT] && !rc_tick_w
    && !start_w[NFCT_MRT] |=> cnt_q[NFCT_MRT] == $past(cnt_q[NFCT_MRT]))
    else $error("mask timer stepped without an oscillator edge");
  nrt_peer_a: assert property (field_on_i && act_w && ctrl_q[NFCT_NRT_FIELD]
    |=> run_q[NFCT_NRT]) else $error("peer field-on did not start no-response timer");
  nrt_off_a: assert property (own_off_w && !ctrl_q[NFCT_NRT_FIELD]
    |=> run_q[NFCT_NRT]) else $error("own field off did not start no-response timer");
  nrt_stopcmd_a: assert property (cmd_stop_nrt_w && !start_w[NFCT_NRT]
    && !expire_w[NFCT_NRT] |=> nrt_quiet_s) else $error("stop command left timer running");
  nrt_uncond_a: assert property (expire_w[NFCT_NRT] && uncond_w && rx_busy_i
    && !rx_off_q |=> nre_flag_o && !rx_off_q) else $error("busy reply was disturbed");
  nrt_cmd_a: assert property (cmd_nrt_w |=> run_q[NFCT_NRT] &&
    cnt_q[NFCT_NRT] == $past(nrt_cnt_q) && pre_q[NFCT_NRT] == 13'h0000)
    else $error("no-response timer not restarted");
  nrt_step64_a: assert property (run_q[NFCT_NRT] && !ctrl_q[NFCT_NRT_STEP]
    |-> pre_q[NFCT_NRT] <= NFCT_STEP64_LAST) else $error("no-response step too long");
  nrt_sticky_a: assert property (expire_w[NFCT_NRT] |=> flag_q[0] && nre_flag_o)
    else $error("no-response expiry not recorded");
  pfw_start_a: assert property (start_w[NFCT_PFW] |=> run_q[NFCT_PFW])
    else $error("wait timer did not start");
  pfw_flag_a: assert property (expire_w[NFCT_PFW] |=> peer_field_wait_flag_o)
    else $error("wait timer expiry not flagged");
  gpt_flag_a: assert property (expire_w[NFCT_GPT] |=> gpt_flag_o && flag_q[2])
    else $error("general timer expiry not flagged");
  gpt_off_a: assert property (gpt_own_off_s |=> field_off_o)
    else $error("general timer did not switch own field off");
  gpt_stop_a: assert property (cmd_stop_all_w && !start_w[NFCT_GPT]
    |=> !run_q[NFCT_GPT]) else $error("general timer running after stop all");
  sq_off_a: assert property (!run_q[NFCT_MRT] |=> !squelch_o)
    else $error("squelch on without mask timer");
  rx_free_a: assert property (!run_q[NFCT_MRT] && !rx_off_q |=> rx_on_o)
    else $error("receiver blocked without cause");
  // Read data stands one cycle only.
  rd_idle_a: assert property (!rd_i |=> rdata_o == 32'h00000000)
    else $error("read data outside read cycle");

endmodule
`default_nettype wire

//--- tb/nfct_carrier_model.sv
// Carrier tick and RC oscillator source facing the timer block.
// Assumes one clock; the carrier tick is given on every clock cycle.
`timescale 1ns/10ps
`default_nettype none
module nfct_carrier_model #(
  parameter int RC_HALF = 740
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  output logic      fc_tick_o,
  output logic      rc_osc_o
);
  int cnt_q;
  // One tick per clock keeps every expected time an exact product.
  assign fc_tick_o = ~rst_i;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q    <= 0;
      rc_osc_o <= 1'b0;
    end else if (cnt_q == RC_HALF - 1) begin
      cnt_q    <= 0;
      rc_osc_o <= ~rc_osc_o;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the protocol timer block.
// Assumes one 40 MHz clock and the carrier model beside the block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import nfct_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_i   = 1'b1;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [3:0]  ev      = 4'h0;
  logic        busy    = 1'b0;
  logic        osc_ok  = 1'b1;
  logic [31:0] r;
  wire logic [31:0] rdata;
  wire logic   fc_tick, rc_osc, rx_on, sq, foff, nre, pfw, gpt;
  wire logic [3:0] outs = {gpt, pfw, nre, foff};
  int          err_count = 0;
  int          compares  = 0;
  int          n, lo, sqn;
  always #12.5 clock_i = ~clock_i;
  nfct_carrier_model CAR (.clock_i(clock_i), .rst_i(rst_i), .fc_tick_o(fc_tick),
    .rc_osc_o(rc_osc));
  nfct_timers DUT (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .fc_tick_i(fc_tick), .rc_osc_i(rc_osc),
    .osc_ok_i(osc_ok), .tx_end_i(ev[0]), .rx_start_i(ev[1]), .rx_end_i(ev[2]),
    .rx_busy_i(busy), .field_on_i(ev[3]), .rx_on_o(rx_on), .squelch_o(sq),
    .field_off_o(foff), .nre_flag_o(nre), .peer_field_wait_flag_o(pfw), .gpt_flag_o(gpt));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic inw(input string nm, input int v, input int l, input int h);
    chk(nm, 32'(v >= l && v <= h), 32'h1);
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clock_i);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic cmd(input logic [7:0] c);
    wreg(NFCT_CMD_OFS, {24'h0, c});
  endtask
  task automatic fire(input logic [3:0] e);
    @(posedge clock_i);
    ev <= e;
    @(posedge clock_i);
    ev <= 4'h0;
  endtask
  // Cycles until output bit i pulses, or -1 when it stays quiet.
  task automatic meas(input int i, input int lim, output int v);
    v = -1;
    for (int k = 1; k <= lim; k++) begin
      @(posedge clock_i);
      #1;
      if (outs[i] === 1'b1) begin
        v = k;
        break;
      end
    end
  endtask
  task automatic mask(input int lim);
    lo  = 0;
    sqn = 0;
    repeat (lim) begin
      @(posedge clock_i);
      #1;
      if (rx_on === 1'b0) lo++;
      if (sq === 1'b1) sqn++;
    end
  endtask
  task automatic clean();
    // Halt every timer before touching configuration.
    cmd(NFCT_CMD_STOP_ALL);
    cmd(NFCT_CMD_STOP_NRT);
    wreg(NFCT_CTRL_OFS, 32'h0);
    wreg(NFCT_STAT_OFS, 32'h7);
    idle(4);
  endtask
  task automatic t_reset();
    chk("rx_on_rst", 32'(rx_on), 32'h1);
    rreg(NFCT_CTRL_OFS, r);
    chk("ctrl_rst", r, 32'h0);
    rreg(8'h1c, r);
    chk("unmapped", r, 32'h0);
  endtask
  task automatic t_nrt();
    wreg(NFCT_NRT_OFS, 32'h2);
    fire(4'h1);
    meas(1, 300, n);
    inw("nrt_time", n, 126, 131);
    idle(2);
    chk("nrt_rx_off", 32'(rx_on), 32'h0);
    rreg(NFCT_STAT_OFS, r);
    chk("nre_sticky", 32'(r[0]), 32'h1);
    wreg(NFCT_STAT_OFS, 32'h1);
    rreg(NFCT_STAT_OFS, r);
    chk("nre_clear", 32'(r[0]), 32'h0);
    wreg(NFCT_CTRL_OFS, 32'h20);
    wreg(NFCT_NRT_OFS, 32'h1);
    fire(4'h1);
    meas(1, 4200, n);
    inw("nrt_4096", n, 4094, 4099);
    clean();
    wreg(NFCT_NRT_OFS, 32'h4);
    fire(4'h1);
    idle(100);
    fire(4'h2);
    meas(1, 300, n);
    inw("reply_stops", n, -1, -1);
    clean();
  endtask
  task automatic t_cmd();
    wreg(NFCT_NRT_OFS, 32'h2);
    cmd(NFCT_CMD_START_NRT);
    rreg(NFCT_STAT_OFS, r);
    chk("nrt_running", 32'(r[5]), 32'h1);
    idle(57);
    cmd(NFCT_CMD_START_NRT);
    meas(1, 300, n);
    inw("nrt_restart", n, 125, 132);
    cmd(NFCT_CMD_START_NRT);
    idle(20);
    cmd(NFCT_CMD_STOP_NRT);
    meas(1, 200, n);
    inw("nrt_stop", n, -1, -1);
    cmd(NFCT_CMD_START_NRT);
    idle(20);
    cmd(NFCT_CMD_STOP_ALL);
    meas(1, 200, n);
    inw("nrt_stop_all", n, -1, -1);
    wreg(NFCT_CTRL_OFS, 32'h40);
    wreg(NFCT_NRT_OFS, 32'h1);
    busy <= 1'b1;
    cmd(NFCT_CMD_START_NRT);
    idle(10);
    cmd(NFCT_CMD_STOP_ALL);
    meas(1, 100, n);
    inw("uncond_time", n, 40, 60);
    idle(2);
    chk("uncond_busy", 32'(rx_on), 32'h1);
    busy <= 1'b0;
    cmd(NFCT_CMD_START_NRT);
    meas(1, 100, n);
    idle(2);
    chk("uncond_idle", 32'(rx_on), 32'h0);
    clean();
  endtask
  task automatic t_mrt();
    wreg(NFCT_CTRL_OFS, 32'h200);
    wreg(NFCT_MRT_OFS, 32'h2);
    wreg(NFCT_NRT_OFS, 32'hffff);
    fire(4'h1);
    mask(400);
    inw("mask_len", lo, 126, 131);
    inw("mask_sq", sqn, 126, 131);
    chk("mask_noflag", 32'(outs), 32'h0);
    clean();
    wreg(NFCT_CTRL_OFS, 32'h410);
    wreg(NFCT_MRT_OFS, 32'h1);
    cmd(NFCT_CMD_START_MRT);
    mask(700);
    inw("mask_512", lo, 508, 515);
    inw("mask_cmd_sq", sqn, 508, 515);
    clean();
  endtask
  task automatic t_gpt();
    wreg(NFCT_CTRL_OFS, 32'h100);
    wreg(NFCT_GPT_OFS, 32'h1);
    fire(4'h2);
    meas(3, 100, n);
    inw("gpt_no_start", n, -1, -1);
    fire(4'h4);
    meas(3, 100, n);
    inw("gpt_rx_end", n, 62, 67);
    cmd(NFCT_CMD_START_GPT);
    idle(30);
    cmd(NFCT_CMD_START_GPT);
    meas(3, 100, n);
    inw("gpt_restart", n, 61, 68);
    clean();
  endtask
  task automatic t_p2p();
    wreg(NFCT_CTRL_OFS, 32'h1);
    wreg(NFCT_GPT_OFS, 32'h1);
    wreg(NFCT_PFW_OFS, 32'h1);
    wreg(NFCT_NRT_OFS, 32'h2);
    fire(4'h1);
    meas(0, 100, n);
    inw("field_off", n, 62, 67);
    meas(2, 100, n);
    inw("peer_wait", n, 62, 67);
    meas(1, 100, n);
    inw("nrt_own_off", n, 58, 70);
    wreg(NFCT_STAT_OFS, 32'h7);
    fire(4'h1);
    meas(0, 100, n);
    idle(20);
    fire(4'h8);
    idle(2);
    chk("mask_peer_on", 32'(rx_on), 32'h0);
    meas(2, 150, n);
    inw("peer_on_time", n, -1, -1);
    clean();
    wreg(NFCT_CTRL_OFS, 32'h81);
    fire(4'h8);
    meas(1, 200, n);
    inw("nrt_peer_on", n, 126, 131);
    clean();
    wreg(NFCT_CTRL_OFS, 32'h3);
    wreg(NFCT_NRT_OFS, 32'h1);
    fire(4'h1);
    meas(1, 150, n);
    inw("passive_nrt", n, -1, -1);
    clean();
  endtask
  task automatic t_lp();
    // Host picks the long step and loads while idle.
    wreg(NFCT_CTRL_OFS, 32'h15);
    wreg(NFCT_MRT_OFS, 32'h2);
    osc_ok <= 1'b0;
    idle(6);
    cmd(NFCT_CMD_START_MRT);
    mask(3300);
    inw("mask_rc", lo, 1476, 2968);
    osc_ok <= 1'b1;
    clean();
  endtask
  task automatic end_sim();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    idle(5);
    rst_i <= 1'b0;
    t_reset();
    $display("reset test done");
    t_nrt();
    $display("no-response test done");
    t_cmd();
    $display("command test done");
    t_mrt();
    $display("mask test done");
    t_gpt();
    $display("general timer test done");
    t_p2p();
    $display("peer test done");
    t_lp();
    $display("low-power test done");
    end_sim();
  end
  initial begin
    #600000;
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
